// *** logic/hsc_switch_control.sv ***
// High-side switch and general pin control register bank
`timescale 1ns/1ps
module hsc_switch_control #(
	parameter int NUM_SWITCH = 4,
	parameter int WAKE_FILTER_CYC = hsc_pkg::WAKE_FILTER_CYC,
	parameter int PWM_SLOW_SLOT_CYC = hsc_pkg::PWM_SLOW_SLOT_CYC,
	parameter int PWM_FAST_SLOT_CYC = hsc_pkg::PWM_FAST_SLOT_CYC,
	parameter int FO_SLOT_CYC = 100
) (
	// Clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// Register access from the serial frame decoder
	input wire logic i_wr_en,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data,
	// Supply and switch fault pins
	input wire logic i_supply_ov,
	input wire logic i_supply_uv,
	input wire logic [3:0] i_switch_fault,
	// Sources from on-chip logic
	input wire logic i_timer_one_level,
	input wire logic i_timer_two_level,
	input wire logic i_pwm_two_level,
	input wire logic i_pwm_one_frequency_select,
	input wire logic i_fault_output_two,
	input wire logic i_fault_output_three,
	// General pin inputs
	input wire logic [1:0] i_gpin_level,
	// Switch and pin drive
	output logic [3:0] o_switch_on,
	output logic [1:0] o_gpin_low_side_on,
	output logic [1:0] o_gpin_high_side_on,
	output logic [1:0] o_gpin_fault_out,
	output logic [1:0] o_gpin_wake
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (NUM_SWITCH != 4) $error("hsc_switch_control: register map serves four switches");
	if (WAKE_FILTER_CYC < 1 || WAKE_FILTER_CYC > 2047) $error("hsc: wake filter range");
	if (PWM_SLOW_SLOT_CYC < 1 || PWM_SLOW_SLOT_CYC > 2047) $error("hsc: pwm slot range");
	if (PWM_FAST_SLOT_CYC < 1 || PWM_FAST_SLOT_CYC > 2047) $error("hsc: pwm slot range");
	if (FO_SLOT_CYC < 1 || FO_SLOT_CYC > 2047) $error("hsc: fault slot range");

	localparam logic [10:0] WAKE_LAST = 11'(WAKE_FILTER_CYC - 1);
	localparam logic [10:0] PWM_SLOW_LAST = 11'(PWM_SLOW_SLOT_CYC - 1);
	localparam logic [10:0] PWM_FAST_LAST = 11'(PWM_FAST_SLOT_CYC - 1);
	localparam logic [10:0] FO_LAST = 11'(FO_SLOT_CYC - 1);
	localparam logic [7:0] PWM_STEP_LAST = 8'(hsc_pkg::PWM_STEPS - 1);
	localparam logic [5:0] FO_STEP_LAST = 6'(hsc_pkg::FO_STEPS - 1);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic ov_disable;
		logic uv_disable;
		logic recovery;
		logic [3:0][2:0] sel;
		logic [7:0] gpin;
		logic [7:0] pwm_duty;
		logic [1:0] ov_sync;
		logic [1:0] uv_sync;
		logic [3:0] flt_meta;
		logic [3:0] flt_sync;
		logic [1:0] pin_meta;
		logic [1:0] pin_sync;
		logic [1:0][10:0] wake_cnt;
		logic [1:0] wake;
		logic [10:0] pwm_slot;
		logic [7:0] pwm_step;
		logic [10:0] fo_slot;
		logic [5:0] fo_step;
		logic [3:0] switch_on;
		logic [1:0] ls_on;
		logic [1:0] hs_on;
		logic [1:0] fault_out;
		logic [7:0] rd_data;
	} hsc_state_s;

	hsc_state_s state_r;
	hsc_state_s state_nxt;

	logic ov_active;
	logic uv_active;
	logic supply_shut;
	logic pwm_one_level;
	logic fo_three_level;
	logic src_level;
	logic [10:0] pwm_last;
	logic [5:0] fo_on;
	logic [2:0] pin_sel;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		src_level = 1'b0;
		pin_sel = hsc_pkg::GPIN_OFF;

		// Pins from outside pass two flops first
		state_nxt.ov_sync = {state_r.ov_sync[0], i_supply_ov};
		state_nxt.uv_sync = {state_r.uv_sync[0], i_supply_uv};
		state_nxt.flt_meta = i_switch_fault;
		state_nxt.flt_sync = state_r.flt_meta;
		state_nxt.pin_meta = i_gpin_level;
		state_nxt.pin_sync = state_r.pin_meta;

		ov_active = state_r.ov_sync[1] & ~state_r.ov_disable;
		uv_active = state_r.uv_sync[1] & ~state_r.uv_disable;
		supply_shut = ov_active | uv_active;

		// Register writes
		if (i_wr_en)
		begin
			if (i_addr == hsc_pkg::ADDR_SHUTDOWN)
			begin
				state_nxt.ov_disable = i_wr_data[hsc_pkg::OV_DISABLE_BIT];
				state_nxt.uv_disable = i_wr_data[hsc_pkg::UV_DISABLE_BIT];
				state_nxt.recovery = i_wr_data[hsc_pkg::RECOVERY_BIT];
			end
			else if (i_addr == hsc_pkg::ADDR_SELECT_12)
			begin
				state_nxt.sel[0] = i_wr_data[hsc_pkg::SEL_LOW_LSB +: 3];
				state_nxt.sel[1] = i_wr_data[hsc_pkg::SEL_HIGH_LSB +: 3];
			end
			else if (i_addr == hsc_pkg::ADDR_SELECT_34)
			begin
				state_nxt.sel[2] = i_wr_data[hsc_pkg::SEL_LOW_LSB +: 3];
				state_nxt.sel[3] = i_wr_data[hsc_pkg::SEL_HIGH_LSB +: 3];
			end
			else if (i_addr == hsc_pkg::ADDR_GPIN)
			begin
				state_nxt.gpin = i_wr_data;
			end
			else if (i_addr == hsc_pkg::ADDR_PWM_ONE)
			begin
				state_nxt.pwm_duty = i_wr_data;
			end
		end

		// Hardware clears beat a same-cycle software write
		for (int i = 0; i < 4; i++)
		begin
			if (state_r.flt_sync[i])
			begin
				state_nxt.sel[i] = hsc_src_off();
			end
			if (supply_shut && !state_r.recovery)
			begin
				state_nxt.sel[i] = hsc_src_off();
			end
		end

		// PWM one: 255 slots per period, slot length from frequency select
		pwm_last = i_pwm_one_frequency_select ? PWM_FAST_LAST : PWM_SLOW_LAST;
		if (state_r.pwm_slot >= pwm_last)
		begin
			state_nxt.pwm_slot = 11'h000;
			state_nxt.pwm_step = (state_r.pwm_step >= PWM_STEP_LAST) ? 8'h00 :
				state_r.pwm_step + 8'h01;
		end
		else
		begin
			state_nxt.pwm_slot = state_r.pwm_slot + 11'h001;
		end
		// Step below duty is on; 255 never leaves step range, so fully on
		pwm_one_level = (state_r.pwm_duty == hsc_pkg::DUTY_FULL) ||
			(state_r.pwm_step < state_r.pwm_duty);

		// Fault output three duty pattern over 40 slots
		case (state_r.gpin[hsc_pkg::FO_DUTY_LSB +: 2])
			2'h0: fo_on = hsc_pkg::FO_ON_20;
			2'h1: fo_on = hsc_pkg::FO_ON_10;
			2'h2: fo_on = hsc_pkg::FO_ON_5;
			default: fo_on = hsc_pkg::FO_ON_2P5;
		endcase
		if (state_r.fo_slot >= FO_LAST)
		begin
			state_nxt.fo_slot = 11'h000;
			state_nxt.fo_step = (state_r.fo_step >= FO_STEP_LAST) ? 6'h00 :
				state_r.fo_step + 6'h01;
		end
		else
		begin
			state_nxt.fo_slot = state_r.fo_slot + 11'h001;
		end
		fo_three_level = i_fault_output_three && (state_r.fo_step < fo_on);

		// Switch drive
		for (int i = 0; i < 4; i++)
		begin
			case (state_r.sel[i])
				hsc_pkg::HSC_SRC_OFF: src_level = 1'b0;
				hsc_pkg::HSC_SRC_ON: src_level = 1'b1;
				hsc_pkg::HSC_SRC_TIMER_ONE: src_level = i_timer_one_level;
				hsc_pkg::HSC_SRC_TIMER_TWO: src_level = i_timer_two_level;
				hsc_pkg::HSC_SRC_PWM_ONE: src_level = pwm_one_level;
				hsc_pkg::HSC_SRC_PWM_TWO: src_level = i_pwm_two_level;
				default: src_level = 1'b0;
			endcase
			// Selectors kept through a supply shutdown under recovery, so the output returns on its own
			state_nxt.switch_on[i] = src_level & ~supply_shut & ~state_r.flt_sync[i];
		end

		// General pins
		for (int p = 0; p < 2; p++)
		begin
			pin_sel = (p == 0) ? state_r.gpin[hsc_pkg::GPIN_ONE_LSB +: 3] :
				state_r.gpin[hsc_pkg::GPIN_TWO_LSB +: 3];
			state_nxt.ls_on[p] = (pin_sel == hsc_pkg::GPIN_LOW_SIDE);
			state_nxt.hs_on[p] = (pin_sel == hsc_pkg::GPIN_HIGH_SIDE);
			if (!pin_sel[2])
			begin
				state_nxt.fault_out[p] = (p == 0) ? i_fault_output_two : fo_three_level;
			end
			else
			begin
				state_nxt.fault_out[p] = 1'b0;
			end
			// Static filter: a new level must hold for the whole filter time
			if (pin_sel != hsc_pkg::GPIN_WAKE || state_r.pin_sync[p] == state_r.wake[p])
			begin
				state_nxt.wake_cnt[p] = 11'h000;
				if (pin_sel != hsc_pkg::GPIN_WAKE)
				begin
					state_nxt.wake[p] = 1'b0;
				end
			end
			else if (state_r.wake_cnt[p] >= WAKE_LAST)
			begin
				state_nxt.wake_cnt[p] = 11'h000;
				state_nxt.wake[p] = state_r.pin_sync[p];
			end
			else
			begin
				state_nxt.wake_cnt[p] = state_r.wake_cnt[p] + 11'h001;
			end
		end

		// Read data, one cycle behind the address
		if (i_addr == hsc_pkg::ADDR_SHUTDOWN)
		begin
			state_nxt.rd_data = 8'h00;
			state_nxt.rd_data[hsc_pkg::OV_DISABLE_BIT] = state_r.ov_disable;
			state_nxt.rd_data[hsc_pkg::UV_DISABLE_BIT] = state_r.uv_disable;
			state_nxt.rd_data[hsc_pkg::RECOVERY_BIT] = state_r.recovery;
		end
		else if (i_addr == hsc_pkg::ADDR_SELECT_12)
		begin
			state_nxt.rd_data = {1'b0, state_r.sel[1], 1'b0, state_r.sel[0]};
		end
		else if (i_addr == hsc_pkg::ADDR_SELECT_34)
		begin
			state_nxt.rd_data = {1'b0, state_r.sel[3], 1'b0, state_r.sel[2]};
		end
		else if (i_addr == hsc_pkg::ADDR_GPIN)
		begin
			state_nxt.rd_data = state_r.gpin;
		end
		else if (i_addr == hsc_pkg::ADDR_PWM_ONE)
		begin
			state_nxt.rd_data = state_r.pwm_duty;
		end
		else
		begin
			state_nxt.rd_data = 8'h00;
		end
	end

	function automatic logic [2:0] hsc_src_off();
		return hsc_pkg::HSC_SRC_OFF;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			state_r <= '0;
			state_r.gpin <= hsc_pkg::RESET_BYTE;
			state_r.pwm_duty <= hsc_pkg::RESET_BYTE;
		end
		else if (i_ce)
		begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rd_data = state_r.rd_data;
	assign o_switch_on = state_r.switch_on;
	assign o_gpin_low_side_on = state_r.ls_on;
	assign o_gpin_high_side_on = state_r.hs_on;
	assign o_gpin_fault_out = state_r.fault_out;
	assign o_gpin_wake = state_r.wake;
endmodule // hsc_switch_control

// *** logic/hsc_pkg.sv ***
// Constants, codes and timing for the high-side switch control block
package hsc_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [6:0] ADDR_SHUTDOWN = 7'h10;
	localparam logic [6:0] ADDR_SELECT_12 = 7'h14;
	localparam logic [6:0] ADDR_SELECT_34 = 7'h15;
	localparam logic [6:0] ADDR_GPIN = 7'h17;
	localparam logic [6:0] ADDR_PWM_ONE = 7'h18;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int OV_DISABLE_BIT = 6;
	localparam int UV_DISABLE_BIT = 5;
	localparam int RECOVERY_BIT = 4;
	localparam int SEL_LOW_LSB = 0;
	localparam int SEL_HIGH_LSB = 4;
	localparam int GPIN_ONE_LSB = 0;
	localparam int GPIN_TWO_LSB = 3;
	localparam int FO_DUTY_LSB = 6;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] DUTY_FULL = 8'hff;
	// ----------------------------------------
	// Source and pin function codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		HSC_SRC_OFF = 3'h0,
		HSC_SRC_ON = 3'h1,
		HSC_SRC_TIMER_ONE = 3'h2,
		HSC_SRC_TIMER_TWO = 3'h3,
		HSC_SRC_PWM_ONE = 3'h4,
		HSC_SRC_PWM_TWO = 3'h5
	} hsc_src_e;
	localparam logic [2:0] GPIN_OFF = 3'h4;
	localparam logic [2:0] GPIN_WAKE = 3'h5;
	localparam logic [2:0] GPIN_LOW_SIDE = 3'h6;
	localparam logic [2:0] GPIN_HIGH_SIDE = 3'h7;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int WAKE_FILTER_US = 16;
	localparam int WAKE_FILTER_CYC = WAKE_FILTER_US * CLK_MHZ;
	localparam int PWM_STEPS = 255;
	localparam int PWM_SLOW_PERIOD_US = 5000;
	localparam int PWM_FAST_PERIOD_US = 2500;
	localparam int PWM_SLOW_SLOT_CYC = PWM_SLOW_PERIOD_US * CLK_MHZ / PWM_STEPS;
	localparam int PWM_FAST_SLOT_CYC = PWM_FAST_PERIOD_US * CLK_MHZ / PWM_STEPS;
	localparam int FO_STEPS = 40;
	localparam logic [5:0] FO_ON_20 = 6'h08;
	localparam logic [5:0] FO_ON_10 = 6'h04;
	localparam logic [5:0] FO_ON_5 = 6'h02;
	localparam logic [5:0] FO_ON_2P5 = 6'h01;
endpackage

// *** testbench/hsc_switch_control_assertions.sv ***
// Port-level assertion checker for the switch control block
`timescale 1ns/1ps
module hsc_switch_control_assertions #(
	parameter int WAKE_FILTER_CYC = 8
) (
	// Clock and control
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// Register port
	input wire logic i_wr_en,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic [7:0] o_rd_data,
	// Faults and pins
	input wire logic i_supply_ov,
	input wire logic i_supply_uv,
	input wire logic [3:0] i_switch_fault,
	input wire logic [1:0] i_gpin_level,
	input wire logic [3:0] o_switch_on,
	input wire logic [1:0] o_gpin_low_side_on,
	input wire logic [1:0] o_gpin_high_side_on,
	input wire logic [1:0] o_gpin_wake
);
	// ----
	// Shadow of shutdown disables, raw high count
	// ----
	logic ov_dis_r, uv_dis_r;
	logic [15:0] high_cnt_r;
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			ov_dis_r <= 1'b0;
			uv_dis_r <= 1'b0;
			high_cnt_r <= 16'h0000;
		end
		else
		begin
			if (i_ce && i_wr_en && i_addr == hsc_pkg::ADDR_SHUTDOWN)
			begin
				ov_dis_r <= i_wr_data[6];
				uv_dis_r <= i_wr_data[5];
			end
			// Saturate so a long high level never wraps to zero
			if (!i_gpin_level[0])
				high_cnt_r <= 16'h0000;
			else if (high_cnt_r != 16'hffff)
				high_cnt_r <= high_cnt_r + 16'h0001;
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	sequence quiet_s;
		!i_supply_ov && !i_supply_uv && !i_switch_fault[0];
	endsequence
	sequence on_write_s;
		i_wr_en && i_addr == hsc_pkg::ADDR_SELECT_12 && i_wr_data[2:0] == 3'h1;
	endsequence
	// ----
	// Assertions
	// ----
	reserved_zero_a: assert property ($past(i_addr) inside {7'h10, 7'h14, 7'h15} |->
		!o_rd_data[7] && !o_rd_data[3] && ($past(i_addr) != 7'h10 || o_rd_data[2:0] == 3'h0))
		else $error("reserved bit read nonzero");
	reset_clear_a: assert property (disable iff (1'b0) i_srst |=>
		o_switch_on == 4'h0 && o_rd_data == 8'h00) else $error("outputs not cleared by reset");
	switch_on_a: assert property (quiet_s [*3] ##0 on_write_s |-> ##2 o_switch_on[0])
		else $error("switch one not on after select");
	ov_shutdown_a: assert property ((i_supply_ov && !ov_dis_r) [*3] |=> o_switch_on == 4'h0)
		else $error("overvoltage left a switch on");
	uv_shutdown_a: assert property ((i_supply_uv && !uv_dis_r) [*3] |=> o_switch_on == 4'h0)
		else $error("undervoltage left a switch on");
	switch_fault_a: assert property (i_switch_fault[0] [*3] |=> !o_switch_on[0])
		else $error("faulted switch still on");
	pin_exclusive_a: assert property ((o_gpin_low_side_on & o_gpin_high_side_on) == 2'b00)
		else $error("pin driven both ways");
	wake_filter_a: assert property ($rose(o_gpin_wake[0]) |-> high_cnt_r >= 16'(WAKE_FILTER_CYC))
		else $error("wake accepted before filter time");
endmodule // hsc_switch_control_assertions

bind hsc_switch_control hsc_switch_control_assertions #(.WAKE_FILTER_CYC(WAKE_FILTER_CYC)) chk_u (
	.i_ref_clk, .i_srst, .i_ce, .i_wr_en, .i_addr, .i_wr_data, .o_rd_data, .i_supply_ov,
	.i_supply_uv, .i_switch_fault, .i_gpin_level, .o_switch_on, .o_gpin_low_side_on,
	.o_gpin_high_side_on, .o_gpin_wake);

// *** testbench/hsc_mcu_model.sv ***
// Controller-side register access model
`timescale 1ns/1ps
module hsc_mcu_model (
	// Clock
	input wire logic i_ref_clk,
	// Register port toward the block
	output logic o_wr_en,
	output logic [6:0] o_addr,
	output logic [7:0] o_wr_data,
	input wire logic [7:0] i_rd_data
);
	initial
	begin
		o_wr_en = 1'b0;
		o_addr = 7'h00;
		o_wr_data = 8'h00;
	end
	// Idle edge after each strobe keeps back-to-back writes apart
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		o_wr_en = 1'b1;
		o_addr = a;
		o_wr_data = d;
		@(posedge i_ref_clk);
		#1;
		o_wr_en = 1'b0;
		o_wr_data = ~d;
		@(posedge i_ref_clk);
		#1;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		o_addr = a;
		@(posedge i_ref_clk);
		#1;
		d = i_rd_data;
	endtask
endmodule // hsc_mcu_model

// *** testbench/tb.sv ***
// Self-checking bench for the switch control block
`timescale 1ns/1ps
module tb;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	logic wr_en;
	logic [6:0] addr, a;
	logic [7:0] wr_data, rd_data, got, v, d;
	logic ov = 1'b0, uv = 1'b0, t1 = 1'b0, t2 = 1'b0, p2 = 1'b0, pf = 1'b0, fo2 = 1'b0, fo3 = 1'b0;
	logic [3:0] sw_fault = 4'h0;
	logic [1:0] gp_lvl = 2'b00;
	logic [3:0] sw_on;
	logic [1:0] lo_on, hi_on, fo_out, wake;
	logic [31:0] seed = 32'h1578b16d;
	logic [31:0] r;
	logic [6:0] regs [5] = '{7'h10, 7'h14, 7'h15, 7'h17, 7'h18};
	int err_total = 0, total_checks = 0, cyc = 0;
	logic ce = 1'b1;
	logic [15:0] high_cnt;
	// Shrunk slot lengths keep a full PWM period short
	localparam int PWM_SLOW = 4;
	localparam int PWM_FAST = PWM_SLOW / 2;
	localparam int FO_SLOT = 2;
	localparam int FO_PERIOD = hsc_pkg::FO_STEPS * FO_SLOT;
	always #5 i_ref_clk = ~i_ref_clk;
	hsc_mcu_model mcu_u (.i_ref_clk, .o_wr_en(wr_en), .o_addr(addr), .o_wr_data(wr_data),
		.i_rd_data(rd_data));
	hsc_switch_control #(.WAKE_FILTER_CYC(8), .PWM_SLOW_SLOT_CYC(PWM_SLOW),
		.PWM_FAST_SLOT_CYC(PWM_FAST), .FO_SLOT_CYC(FO_SLOT)) dut_u (.i_ref_clk, .i_srst, .i_ce(ce),
		.i_wr_en(wr_en), .i_addr(addr),
		.i_wr_data(wr_data), .o_rd_data(rd_data), .i_supply_ov(ov), .i_supply_uv(uv),
		.i_switch_fault(sw_fault), .i_timer_one_level(t1), .i_timer_two_level(t2),
		.i_pwm_two_level(p2), .i_pwm_one_frequency_select(pf), .i_fault_output_two(fo2),
		.i_fault_output_three(fo3), .i_gpin_level(gp_lvl), .o_switch_on(sw_on),
		.o_gpin_low_side_on(lo_on), .o_gpin_high_side_on(hi_on), .o_gpin_fault_out(fo_out),
		.o_gpin_wake(wake));
	// ----
	// Helpers
	// ----
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic exp_src(input logic [2:0] c, input logic p1);
		case (c)
			3'h1: return 1'b1;
			3'h2: return t1;
			3'h3: return t2;
			3'h4: return p1;
			3'h5: return p2;
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic [7:0] exp_pin(input logic [2:0] c);
		return {{2{c == 3'h6}}, {2{c == 3'h7}}, 1'b0, fo2 & (c < 3'h4), {2{c == 3'h5}}};
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e)
			$display("BAD %0t got %h want %h", $time, g, e);
		if (g !== e)
			err_total++;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	// Counts high cycles of switch one or of pin two's fault output
	task automatic count_high(input int len, input logic pick_fo);
		high_cnt = 16'h0000;
		repeat (len)
		begin
			step(1);
			high_cnt += 16'(pick_fo ? fo_out[1] : sw_on[0]);
		end
	endtask
	task automatic rdchk(input logic [6:0] ra, input logic [7:0] e);
		mcu_u.rd(ra, got);
		chk(got, e);
	endtask
	task automatic sup(input logic [7:0] ctl, input logic o, input logic u, input logic x,
		input logic y);
		mcu_u.wr(hsc_pkg::ADDR_SHUTDOWN, ctl);
		mcu_u.wr(hsc_pkg::ADDR_SELECT_12, 8'h01);
		ov = o;
		uv = u;
		step(5);
		chk({7'h0, sw_on[0]}, {7'h0, x});
		ov = 1'b0;
		uv = 1'b0;
		step(5);
		chk({7'h0, sw_on[0]}, {7'h0, y});
	endtask
	task automatic give_verdict();
		$display("Checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end
	// ----
	// Main sequence
	// ----
	initial
	begin
		step(3);
		i_srst = 1'b0;
		foreach (regs[i]) rdchk(regs[i], 8'h00);
		mcu_u.wr(hsc_pkg::ADDR_SHUTDOWN, 8'hff);
		rdchk(hsc_pkg::ADDR_SHUTDOWN, 8'h70);
		mcu_u.wr(hsc_pkg::ADDR_SELECT_12, 8'hdd);
		rdchk(hsc_pkg::ADDR_SELECT_12, 8'h55);
		mcu_u.wr(hsc_pkg::ADDR_SELECT_34, 8'hbc);
		rdchk(hsc_pkg::ADDR_SELECT_34, 8'h34);
		mcu_u.wr(7'h11, 8'hff);
		rdchk(7'h11, 8'h00);
		mcu_u.wr(hsc_pkg::ADDR_SHUTDOWN, 8'h00);
		repeat (6)
		begin
			r = rnd();
			v = r[7:0] | 8'h02;
			mcu_u.wr(hsc_pkg::ADDR_GPIN, v);
			rdchk(hsc_pkg::ADDR_GPIN, v);
			mcu_u.wr(hsc_pkg::ADDR_PWM_ONE, v);
			rdchk(hsc_pkg::ADDR_PWM_ONE, v);
		end
		for (int s = 0; s < 4; s++)
			for (int c = 0; c < 8; c++)
			begin
				r = rnd();
				{t1, t2, p2, pf, fo2, fo3} = r[5:0];
				d = r[6] ? hsc_pkg::DUTY_FULL : 8'h00;
				mcu_u.wr(hsc_pkg::ADDR_PWM_ONE, d);
				v = 8'(c) << (s[0] ? 4 : 0);
				a = s < 2 ? hsc_pkg::ADDR_SELECT_12 : hsc_pkg::ADDR_SELECT_34;
				mcu_u.wr(a, v);
				step(2);
				chk({7'h0, sw_on[s]}, {7'h0, exp_src(3'(c), d[0])});
				if (c < 6) rdchk(a, v);
			end
		mcu_u.wr(hsc_pkg::ADDR_SELECT_12, 8'h11);
		sw_fault = 4'h2;
		step(4);
		sw_fault = 4'h0;
		step(4);
		chk({4'h0, sw_on}, 8'h01);
		rdchk(hsc_pkg::ADDR_SELECT_12, 8'h01);
		sw_fault = 4'h1;
		step(4);
		sw_fault = 4'h0;
		step(4);
		chk({4'h0, sw_on}, 8'h00);
		rdchk(hsc_pkg::ADDR_SELECT_12, 8'h00);
		sup(8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
		rdchk(hsc_pkg::ADDR_SELECT_12, 8'h00);
		sup(8'h10, 1'b0, 1'b1, 1'b0, 1'b1);
		sup(8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
		sup(8'h20, 1'b0, 1'b1, 1'b1, 1'b1);
		gp_lvl = 2'b11;
		fo3 = 1'b0;
		for (int c = 0; c < 8; c++)
		begin
			fo2 = ~c[0];
			mcu_u.wr(hsc_pkg::ADDR_GPIN, 8'(c * 9));
			step(12);
			chk({lo_on, hi_on, fo_out, wake}, exp_pin(3'(c)));
		end
		// ----
		// PWM one duty over one whole period, random frequency select
		// ----
		mcu_u.wr(hsc_pkg::ADDR_SELECT_12, 8'h04);
		for (int k = 0; k < 3; k++)
		begin
			r = rnd();
			pf = r[8];
			v = (k == 0) ? 8'h02 : (r[7:0] | 8'h02);
			mcu_u.wr(hsc_pkg::ADDR_PWM_ONE, v);
			step(4);
			count_high(255 * (pf ? PWM_FAST : PWM_SLOW), 1'b0);
			chk(high_cnt, 16'(v * (pf ? PWM_FAST : PWM_SLOW)));
		end
		// ----
		// Frozen clock enable drops a write
		// ----
		ce = 1'b0;
		mcu_u.wr(hsc_pkg::ADDR_PWM_ONE, ~v);
		ce = 1'b1;
		rdchk(hsc_pkg::ADDR_PWM_ONE, v);
		// ----
		// Fault output three duty on pin two
		// ----
		fo3 = 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			mcu_u.wr(hsc_pkg::ADDR_GPIN, {2'(k), 6'h04});
			count_high(FO_PERIOD, 1'b1);
			chk(high_cnt, 16'((FO_PERIOD / 5) >> k));
		end
		give_verdict();
	end
endmodule // tb
